// [hdl/dpg_consts.vh]
// Register offsets, field positions and reset values of the dual-port GPIO block
`ifndef DPG_CONSTS_VH
`define DPG_CONSTS_VH
`define DPG_IDX_FIRST_PORT      8'h05
`define DPG_IDX_SECOND_PORT     8'h06
`define DPG_IDX_OPTION          8'h81
`define DPG_IDX_FIRST_DIR       8'h85
`define DPG_IDX_SECOND_DIR      8'h86
`define DPG_IDX_ANALOG_CFG      8'h9f
`define DPG_IDX_INT_CONTROL     8'h8b
`define DPG_IDX_CORE_CONTROL    8'h8c
`define DPG_RST_OPTION          8'hff
`define DPG_RST_FIRST_DIR       6'h3f
`define DPG_RST_SECOND_DIR      8'hff
`define DPG_RST_ANALOG_CFG      3'h0
`define DPG_RST_INT_CONTROL     3'h0
`define DPG_RST_LATCH6          6'h00
`define DPG_RST_LATCH8          8'h00
`define DPG_BIT_PULLUP_DIS      7
`define DPG_BIT_EDGE_SEL        6
`define DPG_BIT_CHANGE_FLAG     0
`define DPG_BIT_EXT_FLAG        1
`define DPG_BIT_CHANGE_EN       2
`define DPG_BIT_SLEEP           0
`define DPG_BIT_OPEN_DRAIN      4
`define DPG_BIT_SLAVE_SEL       5
`define DPG_ANALOG_ALL_DIGITAL  3'h6
`endif

// [hdl/dpg_gpio.v]
// Two-port GPIO with pull-ups, external interrupt pin and change detect, APB slave
//
// Function
// - Second port: eight pins, separate direction and output latch registers.
// - Direction one: driver off, pin read as input.
// - Direction zero: pin driven from output latch.
// - Pull-up disable bit 7 of option cleared enables all second-port pull-ups.
// - Pull-up off on any second-port pin set as output.
// - Pull-ups disabled after power-on reset.
// - Only upper four second-port inputs join change compare.
// - Mismatches against last-read value ORed, set change flag bit 0.
// - Port change can wake the core from sleep.
// - Any second-port read or write refreshes the compare latch.
// - Flag keeps setting during mismatch; software accesses port before clearing.
// - Second-port bit 0 is external interrupt, edge from option bit 6.
// - First-port bit 4 is open drain and timer external clock input.
// - First-port bit 5 is serial slave select and analog input.
// - Second-port bits 6 and 7 are serial programming clock and data.
// - Unimplemented register bits read as zero.
// - Port read returns pin levels; write is read-modify-write into latch (the code loads the latch straight from the write data).
// - After power-on reset analog pins read zero digitally.
`include "dpg_consts.vh"
module dpg_gpio (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire [5:0]  first_port_in,
  output reg  [5:0]  first_port_out,
  output reg  [5:0]  first_port_oe_n,
  input  wire [7:0]  second_port_in,
  output reg  [7:0]  second_port_out,
  output reg  [7:0]  second_port_oe_n,
  output reg  [7:0]  second_port_pullup_en,
  output reg  [5:0]  analog_in_sel,
  output reg         timer_ext_clock_in,
  output reg         slave_select_n,
  output reg         prog_clock,
  output reg         prog_data,
  output reg         port_change_irq,
  output reg         ext_irq,
  output reg         wake_up
);

  localparam ST_IDLE   = 3'b001;
  localparam ST_ACCESS = 3'b010;
  localparam ST_DONE   = 3'b100;

  reg [2:0] state;
  reg [7:0] option_control;
  reg [5:0] first_port_direction;
  reg [7:0] second_port_direction;
  reg [5:0] first_latch;
  reg [7:0] second_latch;
  reg [2:0] analog_pin_config;
  reg [2:0] interrupt_control;
  reg       sleep_mode;
  reg [3:0] change_ref;
  reg       ext_prev;
  reg [31:0] next_rdata;
  reg        hit;

  wire       [7:0] idx      = paddr[9:2];
  wire             wr_take  = psel & penable & pwrite & (state == ST_ACCESS);
  wire             rd_take  = psel & penable & ~pwrite & (state == ST_ACCESS);
  wire             b_access = psel & penable & (state == ST_ACCESS) & (idx == `DPG_IDX_SECOND_PORT);
  wire             analog_mode = (analog_pin_config != `DPG_ANALOG_ALL_DIGITAL) &&
                                 (analog_pin_config != 3'h7);
  // Analog-configured pins read zero; any converter config but 6 or 7 makes all first-port pins except bit 4 analog
  wire       [5:0] first_digital = analog_mode ? (first_port_in & 6'h10) : first_port_in;
  wire       [3:0] change_mask  = second_port_direction[7:4];
  wire             mismatch     = |((second_port_in[7:4] ^ change_ref) & change_mask);
  wire             ext_edge     = option_control[`DPG_BIT_EDGE_SEL] ?
                                  (second_port_in[0] & ~ext_prev) : (~second_port_in[0] & ext_prev);

  function [7:0] merge_byte;
    input [7:0] old_val;
    input [7:0] new_val;
    input [3:0] strb;
    begin
      merge_byte = strb[0] ? new_val : old_val;
    end
  endfunction

  // APB: setup, one access cycle with pready, then done
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_IDLE;
    end else begin
      case (state)
        ST_IDLE:   state <= (psel & ~penable) ? ST_ACCESS : ST_IDLE;
        ST_ACCESS: state <= ST_DONE;
        ST_DONE:   state <= (psel & ~penable) ? ST_ACCESS : ST_IDLE;
        default:   state <= ST_IDLE;
      endcase
    end
  end

  always @* begin
    next_rdata = 32'h0000_0000;
    hit        = 1'b1;
    case (idx)
      `DPG_IDX_FIRST_PORT:   next_rdata = {26'h0, first_digital};
      `DPG_IDX_SECOND_PORT:  next_rdata = {24'h0, second_port_in};
      `DPG_IDX_OPTION:       next_rdata = {24'h0, option_control};
      `DPG_IDX_FIRST_DIR:    next_rdata = {26'h0, first_port_direction};
      `DPG_IDX_SECOND_DIR:   next_rdata = {24'h0, second_port_direction};
      `DPG_IDX_ANALOG_CFG:   next_rdata = {29'h0, analog_pin_config};
      `DPG_IDX_INT_CONTROL:  next_rdata = {29'h0, interrupt_control};
      `DPG_IDX_CORE_CONTROL: next_rdata = {31'h0, sleep_mode};
      default: begin
        next_rdata = 32'h0000_0000;
        hit        = 1'b0;
      end
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= (state != ST_ACCESS) & psel & ~penable;
      pslverr <= (state != ST_ACCESS) & psel & ~penable & ~hit;
      if ((state != ST_ACCESS) & psel & ~penable & ~pwrite) begin
        prdata <= next_rdata;
      end
    end
  end

  // Register writes; all direction bits set on every reset
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      option_control        <= `DPG_RST_OPTION;
      first_port_direction  <= `DPG_RST_FIRST_DIR;
      second_port_direction <= `DPG_RST_SECOND_DIR;
      first_latch           <= `DPG_RST_LATCH6;
      second_latch          <= `DPG_RST_LATCH8;
      analog_pin_config     <= `DPG_RST_ANALOG_CFG;
      sleep_mode            <= 1'b0;
    end else begin
      if (wr_take && pready == 1'b1) begin
        case (idx)
          // Plain write: the latch takes the write data as is, and the pin levels are not merged in
          `DPG_IDX_FIRST_PORT:   first_latch <= pwdata[5:0];
          `DPG_IDX_SECOND_PORT:  second_latch <= merge_byte(second_port_in, pwdata[7:0], 4'hf);
          `DPG_IDX_OPTION:       option_control <= pwdata[7:0];
          `DPG_IDX_FIRST_DIR:    first_port_direction <= pwdata[5:0];
          `DPG_IDX_SECOND_DIR:   second_port_direction <= pwdata[7:0];
          `DPG_IDX_ANALOG_CFG:   analog_pin_config <= pwdata[2:0];
          `DPG_IDX_CORE_CONTROL: sleep_mode <= pwdata[`DPG_BIT_SLEEP];
          default:               sleep_mode <= sleep_mode;
        endcase
      end else if (sleep_mode && wake_up) begin
        sleep_mode <= 1'b0;
      end
    end
  end

  // Change detect, external interrupt and flags; set wins over clear
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      change_ref        <= 4'h0;
      // Idle high so the default rising-edge select sees no false edge after reset
      ext_prev          <= 1'b1;
      interrupt_control <= `DPG_RST_INT_CONTROL;
    end else begin
      ext_prev <= second_port_in[0];
      if (b_access && pready) begin
        change_ref <= second_port_in[7:4];
      end
      if (wr_take && pready && idx == `DPG_IDX_INT_CONTROL) begin
        interrupt_control[`DPG_BIT_CHANGE_EN]   <= pwdata[`DPG_BIT_CHANGE_EN];
        // A mismatch in the clearing cycle keeps the flag set
        interrupt_control[`DPG_BIT_CHANGE_FLAG] <= pwdata[`DPG_BIT_CHANGE_FLAG] | mismatch;
        interrupt_control[`DPG_BIT_EXT_FLAG]    <= (pwdata[`DPG_BIT_EXT_FLAG] &
                                                   interrupt_control[`DPG_BIT_EXT_FLAG]) | ext_edge;
      end else begin
        if (mismatch) begin
          interrupt_control[`DPG_BIT_CHANGE_FLAG] <= 1'b1;
        end
        if (ext_edge) begin
          interrupt_control[`DPG_BIT_EXT_FLAG] <= 1'b1;
        end
      end
    end
  end

  // Pin drivers and alternate functions, all registered
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      first_port_out        <= 6'h00;
      first_port_oe_n       <= 6'h3f;
      second_port_out       <= 8'h00;
      second_port_oe_n      <= 8'hff;
      second_port_pullup_en <= 8'h00;
      analog_in_sel         <= 6'h00;
      timer_ext_clock_in    <= 1'b0;
      slave_select_n        <= 1'b1;
      prog_clock            <= 1'b0;
      prog_data             <= 1'b0;
      port_change_irq       <= 1'b0;
      ext_irq               <= 1'b0;
      wake_up               <= 1'b0;
    end else begin
      first_port_out  <= first_latch & ~(6'h01 << `DPG_BIT_OPEN_DRAIN);
      // Open-drain pin enabled only to pull low
      first_port_oe_n <= first_port_direction |
                         ((6'h01 << `DPG_BIT_OPEN_DRAIN) & {6{first_latch[`DPG_BIT_OPEN_DRAIN]}});
      second_port_out  <= second_latch;
      second_port_oe_n <= second_port_direction;
      second_port_pullup_en <= {8{~option_control[`DPG_BIT_PULLUP_DIS]}} & second_port_direction;
      analog_in_sel      <= analog_mode ? 6'h2f : 6'h00;
      timer_ext_clock_in <= first_port_in[`DPG_BIT_OPEN_DRAIN];
      slave_select_n     <= first_port_in[`DPG_BIT_SLAVE_SEL];
      prog_clock         <= second_port_in[6];
      prog_data          <= second_port_in[7];
      port_change_irq    <= interrupt_control[`DPG_BIT_CHANGE_FLAG] & interrupt_control[`DPG_BIT_CHANGE_EN];
      ext_irq            <= interrupt_control[`DPG_BIT_EXT_FLAG];
      wake_up            <= sleep_mode & interrupt_control[`DPG_BIT_CHANGE_FLAG] &
                            interrupt_control[`DPG_BIT_CHANGE_EN];
    end
  end

endmodule

// [testbench/dpg_gpio_properties.sv]
// Port assertions of the dual-port GPIO block
module dpg_gpio_properties (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [5:0]  first_port_out,
  input wire logic [7:0]  second_port_in,
  input wire logic [7:0]  second_port_oe_n,
  input wire logic [7:0]  second_port_pullup_en,
  input wire logic        prog_clock,
  input wire logic        wake_up
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_after_setup: assert property (psel && !penable |=> pready) else $error("no ready");
  a_ready_single: assert property (pready |=> !pready) else $error("ready too long");
  a_err_with_ready: assert property (pslverr |-> pready) else $error("stray error");
  a_upper_zero: assert property (prdata[31:8] == 24'h0) else $error("upper data set");
  a_pullup_off: assert property ((second_port_pullup_en & ~second_port_oe_n) == 8'h00) else $error("pullup");
  a_open_drain_low: assert property (first_port_out[4] == 1'b0) else $error("bit 4 high");
  a_reset_inputs: assert property ($rose(presetn) |-> second_port_oe_n == 8'hff &&
    second_port_pullup_en == 8'h00) else $error("reset state");
  a_prog_copy: assert property ($past(presetn) |-> prog_clock == $past(second_port_in[6])) else $error("prog");
  cover property (pslverr);
  cover property (wake_up);
  cover property ($rose(second_port_pullup_en[7]));
endmodule
bind dpg_gpio dpg_gpio_properties i_dpg_gpio_properties (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr), .first_port_out(first_port_out),
  .second_port_in(second_port_in), .second_port_oe_n(second_port_oe_n),
  .second_port_pullup_en(second_port_pullup_en), .prog_clock(prog_clock), .wake_up(wake_up));

// [testbench/dpg_pin_model.sv]
// Board-side model of the second-port pins
module dpg_pin_model (
  input  wire logic       pclk,
  input  wire logic [7:0] oe_n,
  input  wire logic [7:0] drv,
  input  wire logic [7:0] pullup_en,
  input  wire logic [7:0] ext,
  input  wire logic       ext_en,
  output logic      [7:0] pin
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] drift = 8'h55;
  // Undriven pins without pull-up wander
  always @(posedge pclk) drift <= ~drift;
  assign pin = (~oe_n & drv) | (oe_n & (ext_en ? ext : (pullup_en | drift)));
endmodule

// [testbench/dual_port_gpio_change_irq_test.sv]
// Self-checking bench of the dual-port GPIO block
module dual_port_gpio_change_irq_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, ext_en = 1;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rdv;
  logic        pready, pslverr, err, irq, ext_irq, wake_up;
  logic [5:0]  a_in = 0, a_out, a_oe_n;
  logic [7:0]  b_in, b_out, b_oe_n, b_pu, ext = 0, dir, lat, pv;
  logic [5:0]  a_sel;
  logic        tclk, ss_n, prg_clk, prg_dat;
  int          n_mismatch = 0, checks_done = 0;
  always #50 pclk = ~pclk;
  dpg_gpio i_dpg_gpio (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .first_port_in(a_in),
    .first_port_out(a_out), .first_port_oe_n(a_oe_n), .second_port_in(b_in), .second_port_out(b_out),
    .second_port_oe_n(b_oe_n), .second_port_pullup_en(b_pu), .analog_in_sel(a_sel), .timer_ext_clock_in(tclk),
    .slave_select_n(ss_n), .prog_clock(prg_clk), .prog_data(prg_dat), .port_change_irq(irq), .ext_irq(ext_irq),
    .wake_up(wake_up));
  dpg_pin_model i_dpg_pin_model (.pclk(pclk), .oe_n(b_oe_n), .drv(b_out), .pullup_en(b_pu), .ext(ext),
    .ext_en(ext_en), .pin(b_in));
  function automatic logic [7:0] pins(input logic [7:0] d, input logic [7:0] l, input logic [7:0] e);
    return (~d & l) | (d & e);
  endfunction
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task apb(input logic w, input logic [7:0] idx, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1 && ++n < 20);
    if (n >= 20) n_mismatch++;
    rdv = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task wr(input logic [7:0] idx, input logic [7:0] d);
    apb(1, idx, d);
  endtask
  task rd(input logic [7:0] idx, input logic [7:0] exp);
    apb(0, idx, 0);
    chk(rdv, {24'h0, exp});
  endtask
  task settle;
    repeat (4) @(posedge pclk);
  endtask
  task wrap_up;
    $display("comparisons %0d, mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    #3_000_000;
    n_mismatch++;
    wrap_up;
  end
  initial begin
    void'($urandom(5220));
    repeat (12) @(posedge pclk);
    presetn <= 1;
    rd(8'h81, 8'hff);
    rd(8'h85, 8'h3f);
    rd(8'h86, 8'hff);
    chk(b_pu, 8'h00);
    rd(8'h9f, 8'h00);
    chk(a_sel, 6'h2f);
    a_in <= 6'h3f;
    rd(8'h05, 8'h10);
    apb(0, 8'h40, 0);
    chk(err, 1);
    wr(8'h9f, 8'h06);
    wr(8'h85, 8'h00);
    wr(8'h05, 8'hff);
    settle;
    chk({a_oe_n, a_out}, 12'h42f);
    chk(a_sel, 6'h00);
    chk({tclk, ss_n}, 2'b11);
    wr(8'h85, 8'h3f);
    lat = $urandom;
    a_in <= lat[5:0];
    rd(8'h05, {2'b00, lat[5:0]});
    repeat (6) begin
      dir = $urandom;
      lat = $urandom;
      ext <= $urandom;
      wr(8'h86, dir);
      wr(8'h06, lat);
      settle;
      chk({b_oe_n, b_out}, {dir, lat});
      pv = pins(dir, lat, ext);
      chk({prg_dat, prg_clk}, pv[7:6]);
      rd(8'h06, pv);
    end
    wr(8'h86, 8'h0f);
    wr(8'h81, 8'h7f);
    ext_en <= 0;
    settle;
    chk(b_pu, 8'h0f);
    wr(8'h86, 8'hff);
    rd(8'h06, 8'hff);
    ext_en <= 1;
    ext <= 8'h00;
    wr(8'h8b, 8'h04);
    rd(8'h06, 8'h00);
    wr(8'h8b, 8'h04);
    ext <= 8'h0e;
    settle;
    rd(8'h8b, 8'h04);
    ext <= 8'h2e;
    settle;
    rd(8'h8b, 8'h05);
    chk(irq, 1);
    wr(8'h8b, 8'h04);
    rd(8'h8b, 8'h05);
    wr(8'h06, 8'haf);
    wr(8'h8b, 8'h04);
    rd(8'h8b, 8'h04);
    wr(8'h86, 8'h7f);
    settle;
    rd(8'h8b, 8'h04);
    wr(8'h86, 8'hff);
    rd(8'h06, 8'h2e);
    wr(8'h8b, 8'h04);
    wr(8'h8c, 8'h01);
    ext <= 8'h6f;
    settle;
    rd(8'h8c, 8'h00);
    for (int e = 0; e < 2; e++) begin
      wr(8'h81, e ? 8'hff : 8'hbf);
      ext <= {7'h37, ~e[0]};
      settle;
      wr(8'h8b, 8'h04);
      ext <= {7'h37, e[0]};
      settle;
      chk({ext_irq, 1'b0}, 2'b10);
      wr(8'h8b, 8'h04);
      ext <= {7'h37, ~e[0]};
      settle;
      apb(0, 8'h8b, 0);
      chk(rdv[1], 0);
    end
    presetn <= 0;
    @(posedge pclk);
    presetn <= 1;
    rd(8'h86, 8'hff);
    wrap_up;
  end
endmodule
